// ### logic/rsd_consts.vh
// constants of the redundant stream demultiplexer
`ifndef RSD_CONSTS_VH
`define RSD_CONSTS_VH
`define RSD_FSYNC_LEN 31
`define RSD_BLK_LEN   64
`define RSD_BLK_CNT   12
`define RSD_NCH       3
`define RSD_DLY50_S   50
`define RSD_DLY100_S  100
`define RSD_DLY150_S  150
`define RSD_BIT_RATE  273
`define RSD_CORR_BITS 32
`define RSD_DEINT_LEN 128
`define RSD_FSYNC_WORD 31'h3A4F5C1B
`define RSD_CB_SYNC    31'h1D2B6E47
`define RSD_SP_SYNC    31'h6C3519A5
`endif

// ### logic/rsd_top.v
// redundant stream demultiplexer: per-path deframer/voter/de-interleaver and dual top
`include "rsd_consts.vh"
// -------------------------------------------------------------------------
// Summary of operation
// RL1 - upstream supplies conditioned serial data and bit sync clock
// RL2 - find 31-bit frame sync word outside block capture, pulse frame sync once per match
// RL3 - output shifting timed by frame and bit sync; both forwarded out
// RL4 - capture the 64 bits after each sync word as one block
// RL5 - when twelve blocks held, read them out serially, first in first out
// RL6 - sequencer sends bits in rotation to channels A, B, C
// RL7 - each channel then holds one copy: real time, 50 s or 150 s late
// RL8 - time correlation names real-time, 50 s and 150 s channels
// RL9 - voter inputs: real time +150 s, 50 s copy +100 s, 150 s copy direct
// RL10 - de-interleaver window spots both sync words and splits the streams
// RL11 - each split stream leaves with its own frame sync pulse
// RL12 - two identical demultiplexers handle two arrival paths
// RL13 - voter outputs the value held by at least two inputs
// RL14 - alignment delays are bit-count lines sized from the link bit rate
// -------------------------------------------------------------------------
module rsd_demux #(
   parameter integer BIT_RATE  = `RSD_BIT_RATE,
   parameter integer CORR_BITS = `RSD_CORR_BITS,
   parameter integer DEINT_LEN = `RSD_DEINT_LEN,
   parameter [30:0]  FSYNC     = `RSD_FSYNC_WORD,
   parameter [30:0]  CB_SYNC   = `RSD_CB_SYNC,
   parameter [30:0]  SP_SYNC   = `RSD_SP_SYNC
) (
   input  wire clk,
   input  wire rst_n,
   input  wire sdata_in,
   input  wire bclk_in,
   output reg  bit_sync_q,
   output reg  frame_sync_q,
   output reg  cb_data_q,
   output reg  cb_valid_q,
   output reg  cb_fsync_q,
   output reg  sp_data_q,
   output reg  sp_valid_q,
   output reg  sp_fsync_q,
   output reg  corr_lock_q
);
   // channel sample rate is a third of the link rate
   localparam integer D50  = BIT_RATE * `RSD_DLY50_S / `RSD_NCH;
   localparam integer D100 = BIT_RATE * `RSD_DLY100_S / `RSD_NCH;
   localparam integer D150 = BIT_RATE * `RSD_DLY150_S / `RSD_NCH;
   localparam integer BUF_BITS = `RSD_BLK_LEN * `RSD_BLK_CNT;

   function [1:0] partner;
      input [1:0] r;
      input       j;
      begin
         if (!j)
            partner = (r == 2'h0) ? 2'h1 : 2'h0;
         else
            partner = (r == 2'h2) ? 2'h1 : 2'h2;
      end
   endfunction

   function maj3;
      input a;
      input b;
      input c;
      begin
         maj3 = (a & b) | (a & c) | (b & c);
      end
   endfunction

   // -------------------------------------------------------------------------
   // input synchronisers and bit clock edge
   // -------------------------------------------------------------------------
   reg        dat_s1_q, dat_s2_q, clk_s1_q, clk_s2_q, clk_s3_q;
   wire       tick = clk_s2_q & ~clk_s3_q;
   reg  [30:0] fsr_q;
   wire [30:0] fs_next = {fsr_q[29:0], dat_s2_q};
   reg         cap_q;
   reg  [5:0]  cap_cnt_q;
   reg  [9:0]  wr_ptr_q, rd_ptr_q;
   reg         rd_act_q;
   reg  [0:BUF_BITS-1] buf_q;
   reg  [1:0]  rot_q;
   reg  [2:0]  ch_q;
   reg         step_q;
   wire        fs_hit = tick && !cap_q && (fs_next == FSYNC);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dat_s1_q <= 1'b0;
         dat_s2_q <= 1'b0;
         clk_s1_q <= 1'b0;
         clk_s2_q <= 1'b0;
         clk_s3_q <= 1'b0;
      end else begin
         dat_s1_q <= sdata_in;
         dat_s2_q <= dat_s1_q;
         clk_s1_q <= bclk_in;
         clk_s2_q <= clk_s1_q;
         clk_s3_q <= clk_s2_q;
      end
   end

   // -------------------------------------------------------------------------
   // frame sync, block capture, fifo readout and sequencer
   // -------------------------------------------------------------------------
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fsr_q        <= 31'h0;
         cap_q        <= 1'b0;
         cap_cnt_q    <= 6'h0;
         wr_ptr_q     <= 10'h0;
         rd_ptr_q     <= 10'h0;
         rd_act_q     <= 1'b0;
         buf_q        <= {BUF_BITS{1'b0}};
         rot_q        <= 2'h0;
         ch_q         <= 3'h0;
         step_q       <= 1'b0;
         bit_sync_q   <= 1'b0;
         frame_sync_q <= 1'b0;
      end else begin
         bit_sync_q   <= tick;                              // see RL3
         frame_sync_q <= fs_hit;                            // see RL2
         step_q       <= 1'b0;
         if (tick) begin
            fsr_q <= fs_next;
            // readout runs ahead of refill; placed first so a restart wins over its end
            if (rd_act_q) begin
               ch_q[rot_q] <= buf_q[rd_ptr_q];              // see RL5, RL6
               if (rot_q == 2'h2) begin
                  rot_q  <= 2'h0;
                  step_q <= 1'b1;                           // see RL7
               end else begin
                  rot_q <= rot_q + 2'h1;
               end
               if (rd_ptr_q == BUF_BITS - 1)
                  rd_act_q <= 1'b0;
               else
                  rd_ptr_q <= rd_ptr_q + 10'h1;
            end
            if (fs_hit) begin
               cap_q     <= 1'b1;                           // see RL4
               cap_cnt_q <= 6'h0;
            end else if (cap_q) begin
               buf_q[wr_ptr_q] <= dat_s2_q;                 // see RL4
               cap_cnt_q       <= cap_cnt_q + 6'h1;
               if (cap_cnt_q == 6'h3F)
                  cap_q <= 1'b0;
               if (wr_ptr_q == BUF_BITS - 1) begin
                  wr_ptr_q <= 10'h0;
                  rd_act_q <= 1'b1;                         // see RL5
                  rd_ptr_q <= 10'h0;
               end else begin
                  wr_ptr_q <= wr_ptr_q + 10'h1;
               end
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // correlation, alignment delays and voter
   // -------------------------------------------------------------------------
   reg  [D50-1:0]  dl50_q [0:2];
   reg  [D150-1:0] dl150_q;
   reg  [D100-1:0] dl100_q;
   reg  [15:0]     ccnt_q [0:5];
   reg  [1:0]      rt_q, c50_q, c150_q;
   reg             vote_q, vstep_q;
   integer         i;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         for (i = 0; i < 3; i = i + 1)
            dl50_q[i] <= {D50{1'b0}};
         for (i = 0; i < 6; i = i + 1)
            ccnt_q[i] <= 16'h0;
         dl150_q     <= {D150{1'b0}};
         dl100_q     <= {D100{1'b0}};
         rt_q        <= 2'h0;
         c50_q       <= 2'h1;
         c150_q      <= 2'h2;
         corr_lock_q <= 1'b0;
         vote_q      <= 1'b0;
         vstep_q     <= 1'b0;
      end else begin
         vstep_q <= 1'b0;
         if (step_q) begin
            for (i = 0; i < 3; i = i + 1)
               dl50_q[i] <= {dl50_q[i][D50-2:0], ch_q[i]};  // see RL14
            if (!corr_lock_q) begin
               // candidate i: real time i[2:1], its partner picked by i[0]
               for (i = 0; i < 6; i = i + 1) begin
                  if (dl50_q[i[2:1]][D50-1] == ch_q[partner(i[2:1], i[0])]) begin
                     ccnt_q[i] <= ccnt_q[i] + 16'h1;
                     if (ccnt_q[i] == CORR_BITS - 1) begin
                        corr_lock_q <= 1'b1;                // see RL8
                        rt_q        <= i[2:1];
                        c50_q       <= partner(i[2:1], i[0]);
                        c150_q      <= 2'h3 - i[2:1] - partner(i[2:1], i[0]);
                     end
                  end else begin
                     ccnt_q[i] <= 16'h0;
                  end
               end
            end else begin
               dl150_q <= {dl150_q[D150-2:0], ch_q[rt_q]};  // see RL9, RL14
               dl100_q <= {dl100_q[D100-2:0], ch_q[c50_q]}; // see RL9, RL14
               vote_q  <= maj3(dl150_q[D150-1], dl100_q[D100-1],
                               ch_q[c150_q]);               // see RL13
               vstep_q <= 1'b1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // de-interleaver
   // -------------------------------------------------------------------------
   reg  [DEINT_LEN-1:0] win_q, tcb_q, tsp_q, fcb_q, fsp_q;
   reg  [1:0]           sel_q;
   wire [30:0]          win_new = {win_q[29:0], vote_q};
   wire                 cb_hit  = (win_new == CB_SYNC);
   wire                 sp_hit  = (win_new == SP_SYNC);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         win_q      <= {DEINT_LEN{1'b0}};
         tcb_q      <= {DEINT_LEN{1'b0}};
         tsp_q      <= {DEINT_LEN{1'b0}};
         fcb_q      <= {DEINT_LEN{1'b0}};
         fsp_q      <= {DEINT_LEN{1'b0}};
         sel_q      <= 2'h0;
         cb_data_q  <= 1'b0;
         cb_valid_q <= 1'b0;
         cb_fsync_q <= 1'b0;
         sp_data_q  <= 1'b0;
         sp_valid_q <= 1'b0;
         sp_fsync_q <= 1'b0;
      end else begin
         cb_valid_q <= 1'b0;
         sp_valid_q <= 1'b0;
         cb_fsync_q <= 1'b0;
         sp_fsync_q <= 1'b0;
         if (vstep_q) begin
            win_q <= {win_q[DEINT_LEN-2:0], vote_q};        // see RL10
            tcb_q <= {tcb_q[DEINT_LEN-2:0], sel_q == 2'h1};
            tsp_q <= {tsp_q[DEINT_LEN-2:0], sel_q == 2'h2};
            fcb_q <= {fcb_q[DEINT_LEN-2:0], cb_hit};
            fsp_q <= {fsp_q[DEINT_LEN-2:0], sp_hit};
            if (cb_hit)
               sel_q <= 2'h1;                               // see RL10
            else if (sp_hit)
               sel_q <= 2'h2;
            cb_data_q  <= win_q[DEINT_LEN-1];               // see RL11
            cb_valid_q <= tcb_q[DEINT_LEN-1];
            cb_fsync_q <= fcb_q[DEINT_LEN-1];
            sp_data_q  <= win_q[DEINT_LEN-1];               // see RL11
            sp_valid_q <= tsp_q[DEINT_LEN-1];
            sp_fsync_q <= fsp_q[DEINT_LEN-1];
         end
      end
   end
endmodule

// -------------------------------------------------------------------------
// two identical paths
// -------------------------------------------------------------------------
module rsd_top #(
   parameter integer BIT_RATE  = `RSD_BIT_RATE,
   parameter integer CORR_BITS = `RSD_CORR_BITS,
   parameter integer DEINT_LEN = `RSD_DEINT_LEN
) (
   input  wire       MCLK,
   input  wire       RST_N,
   input  wire [1:0] SDATA,
   input  wire [1:0] BCLK,
   output wire [1:0] BIT_SYNC,
   output wire [1:0] FRAME_SYNC,
   output wire [1:0] CB_DATA,
   output wire [1:0] CB_VALID,
   output wire [1:0] CB_FSYNC,
   output wire [1:0] SP_DATA,
   output wire [1:0] SP_VALID,
   output wire [1:0] SP_FSYNC,
   output wire [1:0] CORR_LOCK
);
   genvar g;
   generate
      for (g = 0; g < 2; g = g + 1) begin : path          // see RL12
         rsd_demux #(
            .BIT_RATE  (BIT_RATE),
            .CORR_BITS (CORR_BITS),
            .DEINT_LEN (DEINT_LEN)
         ) u_dmx (
            .clk          (MCLK),
            .rst_n        (RST_N),
            .sdata_in     (SDATA[g]),
            .bclk_in      (BCLK[g]),
            .bit_sync_q   (BIT_SYNC[g]),
            .frame_sync_q (FRAME_SYNC[g]),
            .cb_data_q    (CB_DATA[g]),
            .cb_valid_q   (CB_VALID[g]),
            .cb_fsync_q   (CB_FSYNC[g]),
            .sp_data_q    (SP_DATA[g]),
            .sp_valid_q   (SP_VALID[g]),
            .sp_fsync_q   (SP_FSYNC[g]),
            .corr_lock_q  (CORR_LOCK[g])
         );
      end
   endgenerate
endmodule

// ### verif/rsd_chk.sv
// assertions on the ports of the dual demultiplexer
module rsd_chk (
   input wire       MCLK,
   input wire       RST_N,
   input wire [1:0] BCLK,
   input wire [1:0] BIT_SYNC,
   input wire [1:0] FRAME_SYNC,
   input wire [1:0] CB_VALID,
   input wire [1:0] CB_FSYNC,
   input wire [1:0] SP_VALID,
   input wire [1:0] SP_FSYNC,
   input wire [1:0] CORR_LOCK
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [6:0] gap_q;
   default clocking dck @(posedge MCLK); endclocking
   default disable iff (!RST_N);
   // bit ticks since the last frame pulse, saturating
   always @(posedge MCLK or negedge RST_N)
      if (!RST_N) gap_q <= 7'h7F;
      else if (FRAME_SYNC[0]) gap_q <= 7'h00;
      else if (BIT_SYNC[0] && gap_q != 7'h7F) gap_q <= gap_q + 7'h01;
   property p_bs_lat; $rose(BCLK[0]) |-> ##[2:5] BIT_SYNC[0]; endproperty
   a_bs_lat: assert property (p_bs_lat) else $error("bit tick late");
   property p_bs_lat1; $rose(BCLK[1]) |-> ##[2:5] BIT_SYNC[1]; endproperty
   a_bs_lat1: assert property (p_bs_lat1) else $error("second path tick late");
   property p_bs_one; BIT_SYNC[0] |=> !BIT_SYNC[0] [*5]; endproperty
   a_bs_one: assert property (p_bs_one) else $error("bit tick repeated");
   property p_fs_tick; FRAME_SYNC[0] |-> BIT_SYNC[0]; endproperty
   a_fs_tick: assert property (p_fs_tick) else $error("frame pulse off tick");
   property p_fs_gap; FRAME_SYNC[0] |-> gap_q >= 7'h40; endproperty
   a_fs_gap: assert property (p_fs_gap) else $error("frame pulse in capture");
   property p_lock; CORR_LOCK[0] |=> CORR_LOCK[0]; endproperty
   a_lock: assert property (p_lock) else $error("lock dropped");
   property p_vote; (CB_VALID[0] || SP_VALID[0]) |-> CORR_LOCK[0]; endproperty
   a_vote: assert property (p_vote) else $error("output before lock");
   property p_excl; !(CB_VALID[0] && SP_VALID[0]); endproperty
   a_excl: assert property (p_excl) else $error("both streams at once");
   property p_step; (CB_VALID[0] || SP_VALID[0]) |=> !(CB_VALID[0] || SP_VALID[0]) [*8];
   endproperty
   a_step: assert property (p_step) else $error("steps too close");
   property p_cbfs; CB_FSYNC[0] |-> CORR_LOCK[0] ##1 !CB_FSYNC[0]; endproperty
   a_cbfs: assert property (p_cbfs) else $error("stream sync pulse wrong");
   property p_spfs; SP_FSYNC[0] |-> CORR_LOCK[0] ##1 !SP_FSYNC[0]; endproperty
   a_spfs: assert property (p_spfs) else $error("second stream sync pulse wrong");
endmodule

bind rsd_top rsd_chk rsd_chk_i (.MCLK(MCLK), .RST_N(RST_N), .BCLK(BCLK),
   .BIT_SYNC(BIT_SYNC), .FRAME_SYNC(FRAME_SYNC), .CB_VALID(CB_VALID),
   .CB_FSYNC(CB_FSYNC), .SP_VALID(SP_VALID), .SP_FSYNC(SP_FSYNC), .CORR_LOCK(CORR_LOCK));

// ### verif/rsd_src.sv
// upstream equipment model: serial data with its bit sync clock
module rsd_src (
   output logic sdata,
   output logic bclk
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      sdata = 1'b0;
      bclk = 1'b0;
   end
   // data moves with clock low, held half a period around the rise
   task automatic send_bit(input logic b);
      sdata <= b;
      #400;
      bclk <= 1'b1;
      #400;
      bclk <= 1'b0;
   endtask
endmodule

// ### verif/tb_rsd_top.sv
// self-checking bench of the dual redundant stream demultiplexer
`include "rsd_consts.vh"
module tb_rsd_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [30:0] FSW = `RSD_FSYNC_WORD;
   localparam logic [30:0] CBW = `RSD_CB_SYNC;
   localparam logic [30:0] SPW = `RSD_SP_SYNC;
   localparam int          NFR = 50;
   logic       mclk;
   logic       rst_n;
   wire  [1:0] sdata, bclk, bit_sync, frame_sync, cb_data, cb_valid, cb_fsync;
   wire  [1:0] sp_data, sp_valid, sp_fsync, corr_lock;
   logic       x [1400];
   int         off [3] = '{300, 200, 0};
   int         fq [2][$];
   logic       cq [2][$];
   logic       sq [2][$];
   logic [1:0] cb_on, sp_on;
   int         nbit [2];
   int         bad_count, n_tests, cyc;

   rsd_top #(.BIT_RATE(6)) rsd_top_i (.MCLK(mclk), .RST_N(rst_n), .SDATA(sdata),
      .BCLK(bclk), .BIT_SYNC(bit_sync), .FRAME_SYNC(frame_sync), .CB_DATA(cb_data),
      .CB_VALID(cb_valid), .CB_FSYNC(cb_fsync), .SP_DATA(sp_data), .SP_VALID(sp_valid),
      .SP_FSYNC(sp_fsync), .CORR_LOCK(corr_lock));
   for (genvar g = 0; g < 2; g++) begin : gp
      rsd_src rsd_src_i (.sdata(sdata[g]), .bclk(bclk[g]));
   end
   always #50 mclk = ~mclk;

   // ---------------------------------------------
   // stimulus and checking
   // ---------------------------------------------
   task automatic compare(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %0h seen %0h", nm, exp, seen);
      end
   endtask

   // payload: channels A, B, C carry x shifted by 300, 200 and 0 samples
   task automatic drive(input int g);
      logic b;
      int   k, d;
      for (int f = 0; f < NFR; f++)
         for (int i = 0; i < 95; i++) begin
            k = f * 64 + i - 31;
            d = i < 31 ? 0 : k / 3 + off[k % 3];
            // from sample 440 one copy in three is flipped, the vote must mask it
            b = i < 31 ? FSW[30 - i] : x[d] ^ (d >= 440 && d % 3 == k % 3);
            if (f == NFR - 1 && i > 30 && i < 62) b = FSW[61 - i];
            if (i == 30) fq[g].push_back(f * 95 + 31);
            if (g == 0) gp[0].rsd_src_i.send_bit(b);
            else gp[1].rsd_src_i.send_bit(b);
         end
   endtask

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   always @(posedge mclk)
      for (int g = 0; g < 2; g++) begin
         nbit[g] += bit_sync[g];
         if (frame_sync[g])
            compare("frame_tick", nbit[g], fq[g].size() ? fq[g].pop_front() : -1);
         if (cb_valid[g] && cb_on[g] && cq[g].size())
            compare("cb_bit", cb_data[g], cq[g].pop_front());
         if (sp_valid[g] && sp_on[g] && sq[g].size())
            compare("sp_bit", sp_data[g], sq[g].pop_front());
         cb_on[g] |= cb_fsync[g];
         sp_on[g] |= sp_fsync[g];
      end

   always @(posedge mclk) begin
      cyc++;
      if (cyc == 60000) begin
         bad_count++;
         print_verdict;
      end
   end

   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      cb_on = 2'h0;
      sp_on = 2'h0;
      void'($urandom(32'hF165));
      foreach (x[i]) x[i] = 1'($urandom);
      for (int i = 0; i < 31; i++) begin
         x[400 + i] = CBW[30 - i];
         x[471 + i] = SPW[30 - i];
      end
      for (int g = 0; g < 2; g++) begin
         for (int i = 0; i < 40; i++) cq[g].push_back(x[431 + i]);
         for (int i = 0; i < 20; i++) sq[g].push_back(x[502 + i]);
      end
      repeat (5) @(posedge mclk);
      rst_n <= 1'b1;
      fork
         drive(0);
         #3100 drive(1);
      join
      $display("test stream and frame timing done");
      repeat (20) @(posedge mclk);
      compare("lock", corr_lock, 2'h3);
      compare("left", fq[0].size() + fq[1].size() + cq[0].size() + cq[1].size()
         + sq[0].size() + sq[1].size(), 0);
      $display("test final state done");
      print_verdict;
   end
endmodule
